// ---- src/icd_defs.vh ----
`ifndef ICD_DEFS_VH
`define ICD_DEFS_VH
// Register byte offsets
`define ICD_A_CTRL      8'h00
`define ICD_A_CHEN      8'h04
`define ICD_A_FAILLO    8'h08
`define ICD_A_RANGE     8'h0C
`define ICD_A_FILT      8'h10
`define ICD_A_ALMEN     8'h14
`define ICD_A_ALMLIM    8'h18
`define ICD_A_SDATA     8'h1C
`define ICD_A_STAT      8'h20
`define ICD_A_ISACMD    8'h24
`define ICD_A_ISARESP   8'h28
`define ICD_A_IRQST     8'h2C
`define ICD_A_IRQMSK    8'h30
// Control field positions
`define ICD_CTRL_HISPD  0
`define ICD_CTRL_REJ50  1
`define ICD_CTRL_SRST   2
`define ICD_CTRL_FAULT  3
// Interrupt event positions
`define ICD_EV_CMD0     0
`define ICD_EV_CMD1     1
`define ICD_EV_RESP     2
`define ICD_EV_HRST     3
`define ICD_EV_DATA     4
`define ICD_EV_W        5
// Reset values
`define ICD_CHEN_RST    16'hFFFF
`define ICD_FAILLO_RST  16'h0000
`define ICD_RANGE_5V    4'h0
`define ICD_FILT_RST    16'h0000
`define ICD_ALMEN_RST   16'h0000
`define ICD_SDATA_RST   16'h0000
// Address window and factory strap value (address bits 8..1 of 0x2B2)
`define ICD_IO_BIT9     1'b1
`define ICD_FACT_STRAPS 8'h59
// Timing
`define ICD_CLK_MHZ     100
`define ICD_SLOT_US     22000
`define ICD_SLOT_CYC    (`ICD_SLOT_US * `ICD_CLK_MHZ)
`define ICD_DATA_SLOTS  35
`define ICD_LAMP_MS     500
`define ICD_LAMP_CYC    (`ICD_LAMP_MS * 1000 * `ICD_CLK_MHZ)
`define ICD_RESP_OKAY   2'b00
`define ICD_RESP_SLVERR 2'b10
`endif

// ---- src/icd_isa_dec.v ----
`timescale 1ns/1ps
`include "icd_defs.vh"
module icd_isa_dec (
  input  wire       clk,      // System clock
  input  wire       rst_n,    // Synchronous reset, active low
  input  wire [9:0] sa_pin,   // ISA address pins
  input  wire       aen_pin,  // Address enable pin
  input  wire       ior_n_pin,// Read strobe pin
  input  wire       iow_n_pin,// Write strobe pin
  input  wire [7:0] sd_pin,   // ISA data in
  input  wire [7:0] straps,   // Captured straps, bit 8..1
  output reg        rd_act,   // Read to our window in progress
  output reg        rd_stb,   // Read strobe ended pulse
  output reg        wr_stb,   // Write strobe ended pulse
  output reg        sel,      // Address bit 0 of cycle
  output reg  [7:0] wdata     // Byte latched on write
);
  reg  [20:0] s1_q;
  reg  [20:0] s2_q;
  reg  [1:0]  s3_q;
  wire        hit;

  ////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on all pins
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 21'h1FFFFF;
      s2_q <= 21'h1FFFFF;
      s3_q <= 2'h3;
    end else begin
      s1_q <= {iow_n_pin, ior_n_pin, aen_pin, sd_pin, sa_pin};
      s2_q <= s1_q;
      s3_q <= s2_q[20:19];
    end
  end

  // Window compare, AEN low only
  assign hit = !s2_q[18] &&
               (s2_q[9:1] == {`ICD_IO_BIT9, straps});

  ////////////////////////////////////////////////////////////////
  // Strobe qualification and byte capture
  always @(posedge clk) begin
    if (!rst_n) begin
      rd_act <= 1'b0;
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      sel    <= 1'b0;
      wdata  <= 8'h00;
    end else begin
      rd_act <= hit && !s2_q[19];
      rd_stb <= rd_act && s2_q[19] && !s3_q[0];
      wr_stb <= hit && s2_q[20] && !s3_q[1];
      if (hit && !s2_q[20]) begin
        wdata <= s2_q[17:10];
      end
      if (hit) begin
        sel <= s2_q[0];
      end
    end
  end
endmodule

// ---- src/icd_lamp.v ----
`timescale 1ns/1ps
`include "icd_defs.vh"
module icd_lamp (
  input  wire clk,    // System clock
  input  wire rst_n,  // Synchronous reset, active low
  input  wire start,  // Soft reset pulse
  input  wire hold,   // Bus reset level
  input  wire fault,  // Board fault level
  output reg  lamp_q  // Lamp drive
);
  parameter LAMP_CYC = `ICD_LAMP_CYC;
  reg [25:0] cnt_q;

  ////////////////////////////////////////////////////////////////
  // Half-second stretch, reloaded while bus reset holds
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= LAMP_CYC[25:0];
      lamp_q <= 1'b1;
    end else begin
      if (start || hold) begin
        cnt_q <= LAMP_CYC[25:0];
      end else if (cnt_q != 26'h0000000) begin
        cnt_q <= cnt_q - 26'h0000001;
      end
      lamp_q <= start || hold || fault || (cnt_q != 26'h0000000);
    end
  end
endmodule

// ---- src/icd_top.v ----
// Behaviour
// - Answer two consecutive I/O addresses only
// - Straps set address bits; installed reads zero
// - Factory straps give base 0x02B2
// - Power, soft, hard reset give one state; IRQ status and mask, ISA command and response clear on power reset only
// - Reset selects standard speed, 60Hz rejection
// - Reset enables channels, open sensor fails high
// - Reset zeroes data; fresh within 35 slots
// - Reset sets 5 volt range everywhere
// - Reset zeroes filter constants
// - Reset disables alarms; limits left untouched
// - Lamp on during reset or fault
// - Lamp half second, longer under bus reset
`timescale 1ns/1ps
`include "icd_defs.vh"
module icd_top (
  input  wire        CLK,       // 100 MHz clock
  input  wire        RSTN,      // Sync reset, active low
  input  wire [7:0]  STRAPS,    // Base straps bit8..bit1, high = removed
  input  wire [9:0]  ISA_SA,    // ISA address
  input  wire        ISA_AEN,   // Address enable
  input  wire        ISA_IOR_N, // I/O read strobe
  input  wire        ISA_IOW_N, // I/O write strobe
  input  wire        ISA_RESET, // Bus reset, active high
  input  wire [7:0]  ISA_SD_I,  // Data from bus
  output reg  [7:0]  ISA_SD_O,  // Data to bus
  output wire        ISA_SD_OE, // Drive enable for data
  output wire        LAMP,      // Status lamp
  output wire        IRQ,       // Interrupt, active high
  input  wire [7:0]  AWADDR,    // Write address
  input  wire        AWVALID,   // Write address valid
  output wire        AWREADY,   // Write address ready
  input  wire [31:0] WDATA,     // Write data
  input  wire [3:0]  WSTRB,     // Byte strobes
  input  wire        WVALID,    // Write data valid
  output wire        WREADY,    // Write data ready
  output reg  [1:0]  BRESP,     // Write response
  output reg         BVALID,    // Write response valid
  input  wire        BREADY,    // Write response ready
  input  wire [7:0]  ARADDR,    // Read address
  input  wire        ARVALID,   // Read address valid
  output wire        ARREADY,   // Read address ready
  output reg  [31:0] RDATA,     // Read data
  output reg  [1:0]  RRESP,     // Read response
  output reg         RVALID,    // Read valid
  input  wire        RREADY     // Read ready
);
  parameter SLOT_CYC = `ICD_SLOT_CYC;
  parameter LAMP_CYC = `ICD_LAMP_CYC;

  reg  [7:0]  strap_s1_q;
  reg  [7:0]  strap_s2_q;
  reg  [7:0]  strap_q;
  reg         hrst_s1_q;
  reg         hrst_s2_q;
  reg         hrst_q;
  reg         srst_q;
  reg  [3:0]  ctrl_q;
  reg  [15:0] chen_q;
  reg  [15:0] faillo_q;
  reg  [3:0]  range_q;
  reg  [15:0] filt_q;
  reg  [15:0] almen_q;
  reg  [15:0] almlim_q;
  reg  [15:0] sdata_q;
  reg  [15:0] cmd_q;
  reg  [15:0] resp_q;
  reg  [`ICD_EV_W-1:0] irqst_q;
  reg  [`ICD_EV_W-1:0] irqmsk_q;
  reg  [21:0] slot_q;
  reg  [5:0]  nslot_q;
  reg         avail_q;
  reg         aw_q;
  reg         w_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [31:0] rd_d;
  reg         rd_ok;
  reg         wr_ok;
  reg  [`ICD_EV_W-1:0] ev_d;
  wire        cfg_rst;
  wire        wr_go;
  wire        rd_act;
  wire        rd_stb;
  wire        wr_stb;
  wire        sel;
  wire [7:0]  isa_wd;
  wire        lamp;
  wire [31:0] wm;
  wire [31:0] lm;

  // Byte-lane merge of a write into a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Strap and bus reset capture
  always @(posedge CLK) begin
    if (!RSTN) begin
      strap_s1_q <= `ICD_FACT_STRAPS;
      strap_s2_q <= `ICD_FACT_STRAPS;
      strap_q    <= `ICD_FACT_STRAPS;
      hrst_s1_q  <= 1'b0;
      hrst_s2_q  <= 1'b0;
      hrst_q     <= 1'b0;
    end else begin
      strap_s1_q <= STRAPS;
      strap_s2_q <= strap_s1_q;
      strap_q    <= strap_s2_q;
      hrst_s1_q  <= ISA_RESET;
      hrst_s2_q  <= hrst_s1_q;
      hrst_q     <= hrst_s2_q;
    end
  end

  // One reset for power-up, soft and bus reset
  assign cfg_rst = !RSTN || srst_q || hrst_s2_q;

  ////////////////////////////////////////////////////////////////
  // Host bus decode
  icd_isa_dec u_dec (
    .clk       (CLK),
    .rst_n     (RSTN),
    .sa_pin    (ISA_SA),
    .aen_pin   (ISA_AEN),
    .ior_n_pin (ISA_IOR_N),
    .iow_n_pin (ISA_IOW_N),
    .sd_pin    (ISA_SD_I),
    .straps    (strap_q),
    .rd_act    (rd_act),
    .rd_stb    (rd_stb),
    .wr_stb    (wr_stb),
    .sel       (sel),
    .wdata     (isa_wd)
  );

  // Drive bus data only during our own read
  assign ISA_SD_OE = rd_act;

  always @(posedge CLK) begin
    if (!RSTN) begin
      ISA_SD_O <= 8'h00;
    end else if (sel) begin
      ISA_SD_O <= {4'h0, ctrl_q[`ICD_CTRL_FAULT], avail_q, hrst_q, lamp};
    end else begin
      ISA_SD_O <= resp_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Lamp timer
  icd_lamp #(.LAMP_CYC(LAMP_CYC)) u_lamp (
    .clk    (CLK),
    .rst_n  (RSTN),
    .start  (srst_q),
    .hold   (hrst_s2_q),
    .fault  (ctrl_q[`ICD_CTRL_FAULT]),
    .lamp_q (lamp)
  );
  assign LAMP = lamp;

  ////////////////////////////////////////////////////////////////
  // Slot counter, data available after the reset wait
  always @(posedge CLK) begin
    if (cfg_rst) begin
      slot_q  <= 22'h000000;
      nslot_q <= 6'h00;
      avail_q <= 1'b0;
    end else if (!avail_q) begin
      if (slot_q == SLOT_CYC[21:0] - 22'h000001) begin
        slot_q  <= 22'h000000;
        nslot_q <= nslot_q + 6'h01;
        avail_q <= (nslot_q == `ICD_DATA_SLOTS - 1);
      end else begin
        slot_q <= slot_q + 22'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI write channel capture
  assign AWREADY = !aw_q;
  assign WREADY  = !w_q;
  assign wr_go   = aw_q && w_q && !BVALID;

  always @(posedge CLK) begin
    if (!RSTN) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      BVALID   <= 1'b0;
      BRESP    <= `ICD_RESP_OKAY;
    end else begin
      if (AWVALID && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= AWADDR;
      end
      if (WVALID && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_go) begin
        aw_q   <= 1'b0;
        w_q    <= 1'b0;
        BVALID <= 1'b1;
        BRESP  <= wr_ok ? `ICD_RESP_OKAY : `ICD_RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Write address map check
  always @* begin
    case (awaddr_q)
      `ICD_A_CTRL, `ICD_A_CHEN, `ICD_A_FAILLO, `ICD_A_RANGE, `ICD_A_FILT,
      `ICD_A_ALMEN, `ICD_A_ALMLIM, `ICD_A_SDATA, `ICD_A_ISARESP,
      `ICD_A_IRQST, `ICD_A_IRQMSK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  assign wm = merge(32'h00000000, wdata_q, wstrb_q);
  // Lane mask, ones on every strobed byte
  assign lm = merge(32'h00000000, 32'hFFFFFFFF, wstrb_q);

  ////////////////////////////////////////////////////////////////
  // Configuration registers, restored by any reset
  always @(posedge CLK) begin
    if (cfg_rst) begin
      ctrl_q   <= 4'h0;
      chen_q   <= `ICD_CHEN_RST;
      faillo_q <= `ICD_FAILLO_RST;
      range_q  <= `ICD_RANGE_5V;
      filt_q   <= `ICD_FILT_RST;
      almen_q  <= `ICD_ALMEN_RST;
      sdata_q  <= `ICD_SDATA_RST;
    end else if (wr_go) begin
      case (awaddr_q)
        `ICD_A_CTRL: begin
          ctrl_q <= ((ctrl_q & ~lm[3:0]) | wm[3:0]) & 4'hB; // Soft reset bit not kept
        end
        `ICD_A_CHEN:   chen_q   <= (chen_q & ~lm[15:0]) | wm[15:0];
        `ICD_A_FAILLO: faillo_q <= (faillo_q & ~lm[15:0]) | wm[15:0];
        `ICD_A_RANGE:  range_q  <= (range_q & ~lm[3:0]) | wm[3:0];
        `ICD_A_FILT:   filt_q   <= (filt_q & ~lm[15:0]) | wm[15:0];
        `ICD_A_ALMEN:  almen_q  <= (almen_q & ~lm[15:0]) | wm[15:0];
        `ICD_A_SDATA:  sdata_q  <= (sdata_q & ~lm[15:0]) | wm[15:0];
        default: begin
        end
      endcase
    end
  end

  // Alarm limits keep no reset value
  always @(posedge CLK) begin
    if (wr_go && awaddr_q == `ICD_A_ALMLIM) begin
      almlim_q <= wdata_q[15:0];
    end
  end

  // Soft reset pulse from the control register
  always @(posedge CLK) begin
    if (!RSTN) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_go && awaddr_q == `ICD_A_CTRL && wm[`ICD_CTRL_SRST];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Host command and response bytes
  always @(posedge CLK) begin
    if (!RSTN) begin
      cmd_q  <= 16'h0000;
      resp_q <= 16'h0000;
    end else begin
      if (wr_stb) begin
        cmd_q[sel*8 +: 8] <= isa_wd;
      end
      if (wr_go && awaddr_q == `ICD_A_ISARESP) begin
        resp_q <= (resp_q & ~lm[15:0]) | wm[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  always @* begin
    ev_d = {`ICD_EV_W{1'b0}};
    ev_d[`ICD_EV_CMD0] = wr_stb && !sel;
    ev_d[`ICD_EV_CMD1] = wr_stb && sel;
    ev_d[`ICD_EV_RESP] = rd_stb && !sel;
    ev_d[`ICD_EV_HRST] = hrst_s2_q && !hrst_q;
    ev_d[`ICD_EV_DATA] = !cfg_rst && !avail_q && nslot_q == `ICD_DATA_SLOTS - 1 &&
                         slot_q == SLOT_CYC[21:0] - 22'h000001;
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      irqst_q  <= {`ICD_EV_W{1'b0}};
      irqmsk_q <= {`ICD_EV_W{1'b0}};
    end else begin
      if (wr_go && awaddr_q == `ICD_A_IRQST) begin
        irqst_q <= (irqst_q & ~wm[`ICD_EV_W-1:0]) | ev_d;
      end else begin
        irqst_q <= irqst_q | ev_d;
      end
      if (wr_go && awaddr_q == `ICD_A_IRQMSK) begin
        irqmsk_q <= (irqmsk_q & ~lm[`ICD_EV_W-1:0]) | wm[`ICD_EV_W-1:0];
      end
    end
  end

  assign IRQ = |(irqst_q & irqmsk_q);

  ////////////////////////////////////////////////////////////////
  // AXI read channel
  assign ARREADY = !RVALID;

  always @* begin
    rd_ok = 1'b1;
    case (ARADDR)
      `ICD_A_CTRL:    rd_d = {28'h0, ctrl_q};
      `ICD_A_CHEN:    rd_d = {16'h0, chen_q};
      `ICD_A_FAILLO:  rd_d = {16'h0, faillo_q};
      `ICD_A_RANGE:   rd_d = {28'h0, range_q};
      `ICD_A_FILT:    rd_d = {16'h0, filt_q};
      `ICD_A_ALMEN:   rd_d = {16'h0, almen_q};
      `ICD_A_ALMLIM:  rd_d = {16'h0, almlim_q};
      `ICD_A_SDATA:   rd_d = {16'h0, avail_q ? sdata_q : 16'h0000};
      `ICD_A_STAT:    rd_d = {20'h0, strap_q, hrst_q, srst_q, avail_q, lamp};
      `ICD_A_ISACMD:  rd_d = {16'h0, cmd_q};
      `ICD_A_ISARESP: rd_d = {16'h0, resp_q};
      `ICD_A_IRQST:   rd_d = {27'h0, irqst_q};
      `ICD_A_IRQMSK:  rd_d = {27'h0, irqmsk_q};
      default: begin
        rd_d  = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h00000000;
      RRESP  <= `ICD_RESP_OKAY;
    end else if (ARVALID && !RVALID) begin
      RVALID <= 1'b1;
      RDATA  <= rd_d;
      RRESP  <= rd_ok ? `ICD_RESP_OKAY : `ICD_RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule

// ---- tb/icd_top_chk_asserts.sv ----
`timescale 1ns/1ps
module icd_top_chk #(
  parameter LAMP_CYC = 20
) (
  input logic        CLK,       // Clock
  input logic        RSTN,      // Reset, active low
  input logic [7:0]  STRAPS,    // Base straps
  input logic [9:0]  ISA_SA,    // Address
  input logic        ISA_AEN,   // Address enable
  input logic        ISA_IOR_N, // Read strobe
  input logic        ISA_RESET, // Bus reset
  input logic        ISA_SD_OE, // Data drive
  input logic        LAMP,      // Lamp
  input logic        AWVALID,   // AW valid
  input logic        AWREADY,   // AW ready
  input logic        WVALID,    // W valid
  input logic        WREADY,    // W ready
  input logic        BVALID,    // B valid
  input logic        BREADY,    // B ready
  input logic        ARVALID,   // AR valid
  input logic        ARREADY,   // AR ready
  input logic [31:0] RDATA,     // Read data
  input logic        RVALID,    // R valid
  input logic        RREADY     // R ready
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  // Lamp on-time and age of last read aimed at our window
  int unsigned lamp_n_q;
  int unsigned hit_age_q;
  always @(posedge CLK) begin
    lamp_n_q  <= LAMP ? lamp_n_q + 1 : 0;
    hit_age_q <= (!ISA_IOR_N && !ISA_AEN && ISA_SA[9:1] == {1'b1, STRAPS}) ? 0 : hit_age_q + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Named steps
  sequence s_both_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_hrst_held;
    ISA_RESET [*5];
  endsequence
  property p_lamp_rel; $rose(RSTN) |-> LAMP [*8]; endproperty
  property p_lamp_hrst; s_hrst_held |-> LAMP; endproperty
  property p_lamp_after; $fell(ISA_RESET) |-> ##4 LAMP [*8]; endproperty
  property p_lamp_len; $fell(LAMP) |-> lamp_n_q >= LAMP_CYC - 1; endproperty
  property p_oe_rise; $rose(ISA_SD_OE) |-> hit_age_q <= 5; endproperty
  property p_oe_hold; ISA_SD_OE |-> hit_age_q <= 7; endproperty
  property p_wr_resp; s_both_taken |-> ##[1:2] BVALID; endproperty
  property p_b_hold; BVALID && !BREADY |=> BVALID; endproperty
  property p_rd_lat; ARVALID && ARREADY |=> RVALID; endproperty
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_lamp_rel: assert property (p_lamp_rel)
    else $error("lamp short after reset");
  a_lamp_hrst: assert property (p_lamp_hrst)
    else $error("lamp off under bus reset");
  a_lamp_after: assert property (p_lamp_after)
    else $error("lamp short after bus reset");
  a_lamp_len: assert property (p_lamp_len)
    else $error("lamp pulse too short");
  a_oe_rise: assert property (p_oe_rise)
    else $error("data driven without matching read");
  a_oe_hold: assert property (p_oe_hold)
    else $error("data driven after read ended");
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  a_r_hold: assert property (p_r_hold)
    else $error("read data unstable");
endmodule

bind icd_top icd_top_chk #(.LAMP_CYC(LAMP_CYC)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .STRAPS(STRAPS), .ISA_SA(ISA_SA), .ISA_AEN(ISA_AEN),
  .ISA_IOR_N(ISA_IOR_N), .ISA_RESET(ISA_RESET), .ISA_SD_OE(ISA_SD_OE), .LAMP(LAMP),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY));

// ---- tb/icd_isa_host.sv ----
`timescale 1ns/1ps
module icd_isa_host (
  input  logic       CLK,   // Clock
  input  logic [7:0] SD_O,  // Data from card
  input  logic       SD_OE, // Card drives data
  output logic [9:0] SA,    // Address
  output logic       AEN,   // Address enable
  output logic       IOR_N, // Read strobe
  output logic       IOW_N, // Write strobe
  output logic [7:0] SD     // Data to card
);
  // Idle bus
  initial begin
    SA = 10'h000;
    AEN = 1'b1;
    IOR_N = 1'b1;
    IOW_N = 1'b1;
    SD = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One I/O cycle, six clock strobe, six idle
  task automatic cyc(input logic [9:0] a, input logic en, input logic wr,
                     input logic [7:0] d, output logic [7:0] q, output logic oe);
    oe = 1'b0;
    q = 8'h00;
    @(posedge CLK);
    SA <= a;
    AEN <= en;
    SD <= d;
    @(posedge CLK);
    IOW_N <= !wr;
    IOR_N <= wr;
    repeat (6) begin
      @(posedge CLK);
      if (SD_OE) begin
        oe = 1'b1;
        q = SD_O;
      end
    end
    IOW_N <= 1'b1;
    IOR_N <= 1'b1;
    repeat (6) @(posedge CLK);
    SD <= ~d;  // Released data shows no stale byte
    SA <= ~a;
    AEN <= 1'b1;
  endtask
endmodule

// ---- tb/test_isa_card_decode_and_reset.sv ----
`timescale 1ns/1ps
module test_isa_card_decode_and_reset;
  localparam SLOT = 10;
  localparam LCYC = 20;
  logic        clk, rstn, hrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sd_oe, lamp, irq;
  logic        aen, ior_n, iow_n;
  logic [7:0]  straps, awaddr, araddr, sd_o, sd_i;
  logic [9:0]  sa;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, n_checks;

  icd_top #(.SLOT_CYC(SLOT), .LAMP_CYC(LCYC)) u_dut (
    .CLK(clk), .RSTN(rstn), .STRAPS(straps), .ISA_SA(sa), .ISA_AEN(aen),
    .ISA_IOR_N(ior_n), .ISA_IOW_N(iow_n), .ISA_RESET(hrst), .ISA_SD_I(sd_i),
    .ISA_SD_O(sd_o), .ISA_SD_OE(sd_oe), .LAMP(lamp), .IRQ(irq), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));
  icd_isa_host u_host (.CLK(clk), .SD_O(sd_o), .SD_OE(sd_oe), .SA(sa), .AEN(aen),
    .IOR_N(ior_n), .IOW_N(iow_n), .SD(sd_i));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus tasks, verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 1;
    w = 1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    rready <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axr(a, d);
    chk(nm, d, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults(input string nm);
    rdc("ctrl", 8'h00, 32'h0000_0000);
    rdc("chen", 8'h04, 32'h0000_FFFF);
    rdc("faillo", 8'h08, 32'h0000_0000);
    rdc("range", 8'h0C, 32'h0000_0000);
    rdc("filt", 8'h10, 32'h0000_0000);
    rdc("almen", 8'h14, 32'h0000_0000);
    rdc("sdata", 8'h1C, 32'h0000_0000);
    $display("defaults after %s done", nm);
  endtask
  task automatic t_decode(input logic [9:0] b);
    logic [7:0] q;
    logic oe;
    logic [31:0] d;
    logic [1:0] r;
    straps <= b[8:1];
    repeat (4) @(posedge clk);
    u_host.cyc(b, 1'b0, 1'b1, 8'hA5, q, oe);
    u_host.cyc(b | 10'h001, 1'b0, 1'b1, 8'h3C, q, oe);
    u_host.cyc(b ^ 10'h004, 1'b0, 1'b1, 8'hFF, q, oe);
    u_host.cyc(b, 1'b1, 1'b1, 8'h77, q, oe);
    axr(8'h24, d);
    chk("isacmd", {16'h0000, d[15:0]}, 32'h0000_3CA5);
    axw(8'h28, {24'h0, b[8:1] ^ 8'h5A}, r);
    u_host.cyc(b, 1'b0, 1'b0, 8'h00, q, oe);
    chk("rd lo", q, b[8:1] ^ 8'h5A);
    u_host.cyc(b | 10'h001, 1'b0, 1'b0, 8'h00, q, oe);
    chk("rd oe", oe, 1'b1);
    chk("rd hi", q[7:4], 4'h0);
    u_host.cyc(b ^ 10'h002, 1'b0, 1'b0, 8'h00, q, oe);
    chk("foreign oe", oe, 1'b0);
    $display("decode at base %h done", b);
  endtask
  task automatic t_reset(input bit hard);
    logic [1:0] r;
    logic [31:0] d;
    axw(8'h00, 32'h0000_0003, r);
    axw(8'h04, 32'h0000_00A5, r);
    axw(8'h08, 32'h0000_FFFF, r);
    axw(8'h0C, 32'h0000_0003, r);
    axw(8'h10, 32'h0000_0005, r);
    axw(8'h14, 32'h0000_0003, r);
    rdc("chen set", 8'h04, 32'h0000_00A5);
    axw(8'h40, 32'h0000_0001, r);
    chk("unmapped", r, 2'b10);
    axr(8'h40, d);
    chk("rresp", rresp, 2'b10);
    chk("rd unmapped", d, 32'h0000_0000);
    if (hard) begin
      hrst <= 1'b1;
      repeat (60) @(posedge clk);
      chk("lamp held", lamp, 1'b1);
      hrst <= 1'b0;
    end
    else axw(8'h00, 32'h0000_0004, r);
    repeat (4) @(posedge clk);
    chk("lamp on", lamp, 1'b1);
    repeat (LCYC + 10) @(posedge clk);
    chk("lamp off", lamp, 1'b0);
    t_defaults(hard ? "hard" : "soft");
    axr(8'h20, d);
    chk("not avail", d[1], 1'b0);
    repeat (36 * SLOT) @(posedge clk);
    axr(8'h20, d);
    chk("avail", d[1], 1'b1);
    if (hard) begin
      chk("irq masked", irq, 1'b0);
      axr(8'h2C, d);
      chk("irq st", d[3:0], 4'hF);
      axw(8'h30, 32'h0000_0008, r);
      chk("irq on", irq, 1'b1);
      axw(8'h2C, 32'h0000_001F, r);
      chk("irq clr", irq, 1'b0);
    end
    axw(8'h00, 32'h0000_0008, r);
    repeat (3) @(posedge clk);
    chk("fault lamp", lamp, 1'b1);
    repeat (LCYC) @(posedge clk);
    axw(8'h00, 32'h0000_0000, r);
    $display("reset kind %0d done", hard);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    rstn = 1'b0;
    hrst = 1'b0;
    straps = 8'h59;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_defaults("power");
    t_decode(10'h2B2);
    t_decode(10'h200);
    t_decode(10'h3FE);
    t_reset(1'b0);
    t_reset(1'b1);
    report_and_stop;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
